// ===== common/ccs_pkg.sv
// Shared constants and types for the CPU cycle sequencer and its branch evaluator
// What this block does
// - Branch target: signed byte from next address
// - Zero branches test accumulator, no flag
// - Decrement operand, branch when result nonzero
// - Compare two bytes, branch when unequal
// - Unsigned compare sets carry when first smaller
// - Machine cycle is six states
// - Each state is two oscillator periods
// - Each state has phase one, phase two
// - Two fetches; unused byte dropped, counter held
// - Opcode in state one, second fetch state four
// - External data move: two cycles, second unfetched
// - Same sequence for internal and external code
// - External code: two read strobes per cycle
// - Data access drops two read strobes, doubled
// - Low address on port zero, high port two
// - Internal code: no strobe, no program address
// - Latch strobe twice per cycle, one dropped
`default_nettype none

package ccs_pkg;

  localparam int CCS_STATES = 6;
  localparam int CCS_PHASES = 2;
  localparam int CCS_OSC_PER_CYCLE = CCS_STATES * CCS_PHASES;

  localparam logic [15:0] CCS_PC_RESET = 16'h0000;
  localparam logic [7:0] CCS_BYTE_RESET = 8'h00;
  localparam logic [7:0] CCS_BYTE_ONE = 8'h01;
  localparam logic [15:0] CCS_PC_STEP = 16'h0001;

  // Address slots: the latch strobe in phase two of the state before the read window
  localparam int CCS_SLOT_OPCODE_ALE = 5;
  localparam int CCS_SLOT_SECOND_ALE = 2;

  typedef enum logic [2:0] {
    CCS_S1,
    CCS_S2,
    CCS_S3,
    CCS_S4,
    CCS_S5,
    CCS_S6
  } ccs_state_e;

  typedef enum logic [2:0] {
    CCS_BR_NONE,
    CCS_BR_ACC_ZERO,
    CCS_BR_ACC_NONZERO,
    CCS_BR_DEC_NONZERO,
    CCS_BR_CMP_UNEQUAL
  } ccs_branch_e;

endpackage : ccs_pkg

`default_nettype wire

// ===== hdl/ccs_branch_eval.sv
// Relative conditional branch evaluation for the sequencer
`default_nettype none

module ccs_branch_eval (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Request
  input wire logic eval,
  input wire ccs_pkg::ccs_branch_e kind,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] byte_a,
  input wire logic [7:0] byte_b,
  input wire logic [7:0] rel,
  input wire logic [15:0] next_pc,
  // Result, valid from the cycle after eval
  output logic taken,
  output logic [15:0] target,
  output logic carry_value,
  output logic carry_write,
  output logic [7:0] dec_value,
  output logic dec_write
);
  import ccs_pkg::*;

  logic [7:0] next_dec;
  logic next_taken;
  logic [15:0] rel_ext;

  assign next_dec = byte_a - CCS_BYTE_ONE;
  assign rel_ext = {{8{rel[7]}}, rel};

  always_comb begin
    next_taken = 1'b0;
    unique case (kind)
      CCS_BR_NONE: next_taken = 1'b0;
      CCS_BR_ACC_ZERO: next_taken = (acc_value == CCS_BYTE_RESET);
      CCS_BR_ACC_NONZERO: next_taken = (acc_value != CCS_BYTE_RESET);
      CCS_BR_DEC_NONZERO: next_taken = (next_dec != CCS_BYTE_RESET);
      CCS_BR_CMP_UNEQUAL: next_taken = (byte_a != byte_b);
      default: next_taken = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      taken <= 1'b0;
      target <= CCS_PC_RESET;
    end else if (clk_en) begin
      taken <= eval & next_taken;
      // Wraps modulo 64 KiB, as the program counter does
      target <= next_pc + rel_ext;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      carry_value <= 1'b0;
      carry_write <= 1'b0;
    end else if (clk_en) begin
      carry_write <= eval && (kind == CCS_BR_CMP_UNEQUAL);
      carry_value <= (byte_a < byte_b);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dec_value <= CCS_BYTE_RESET;
      dec_write <= 1'b0;
    end else if (clk_en) begin
      dec_write <= eval && (kind == CCS_BR_DEC_NONZERO);
      dec_value <= next_dec;
    end
  end

endmodule : ccs_branch_eval

`default_nettype wire

// ===== hdl/ccs_sequencer.sv
// Machine-cycle sequencer: states, fetches, bus strobes and branch handling
`default_nettype none

module ccs_sequencer #(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Strap pin: high selects external program memory
  input wire logic external_program,
  // On-chip program store, same clock
  output logic [15:0] code_addr,
  input wire logic [7:0] code_data,
  // Decode information for the instruction in the instruction register
  input wire logic instr_two_cycle,
  input wire logic instr_is_external_data_move,
  input wire logic need_operand,
  input wire ccs_pkg::ccs_branch_e branch_kind,
  // Datapath operands and external data transfer
  input wire logic [7:0] acc_value,
  input wire logic [7:0] byte_a,
  input wire logic [7:0] byte_b,
  input wire logic [15:0] data_addr,
  input wire logic data_write,
  input wire logic [7:0] data_wr_byte,
  output logic [7:0] data_rd_byte,
  output logic data_rd_valid,
  // Instruction state
  output logic [7:0] instr_reg,
  output logic [7:0] operand_last,
  output logic [7:0] operand_prev,
  output logic [15:0] pc,
  output ccs_pkg::ccs_state_e state,
  output logic phase2,
  output logic second_cycle,
  output logic instr_done,
  // Branch results
  output logic carry_value,
  output logic carry_write,
  output logic [7:0] dec_value,
  output logic dec_write,
  // External bus pins
  output logic address_latch_strobe,
  output logic program_store_read_strobe_n,
  output logic data_strobe_n,
  output logic data_write_n,
  output logic [7:0] low_address_data_port_o,
  output logic low_address_data_port_oe,
  input wire logic [7:0] low_address_data_port_i,
  output logic [7:0] high_address_port_o,
  output logic high_address_port_oe
);
  import ccs_pkg::*;

  // Only a 16-bit program counter is served
  if (PC_W != 16) begin : g_pc_width_check
    $error("ccs_sequencer: program counter must be 16 bits");
  end

  // Pin synchronisers: first stage feeds only the second
  logic ext_meta;
  logic ext_sync;
  logic [7:0] bus_meta;
  logic [7:0] bus_sync;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      bus_meta <= CCS_BYTE_RESET;
      bus_sync <= CCS_BYTE_RESET;
    end else if (clk_en) begin
      ext_meta <= external_program;
      ext_sync <= ext_meta;
      bus_meta <= low_address_data_port_i;
      bus_sync <= bus_meta;
    end
  end

  // State and phase counter; one ref_clk is one oscillator period
  ccs_state_e next_state;
  logic last_cycle;
  logic external_data_move_cycle2;
  logic fetch_ok;
  logic [7:0] fetch_byte;
  logic end_of_cycle;

  always_comb begin
    next_state = state;
    unique case (state)
      CCS_S1: next_state = CCS_S2;
      CCS_S2: next_state = CCS_S3;
      CCS_S3: next_state = CCS_S4;
      CCS_S4: next_state = CCS_S5;
      CCS_S5: next_state = CCS_S6;
      CCS_S6: next_state = CCS_S1;
      default: next_state = CCS_S1;
    endcase
  end

  assign end_of_cycle = phase2 && (state == CCS_S6);
  assign last_cycle = second_cycle || !instr_two_cycle;
  // Only the second cycle of an external data move skips program fetches
  assign external_data_move_cycle2 = second_cycle && instr_is_external_data_move;
  assign fetch_ok = !external_data_move_cycle2;
  // Fetched byte path differs by source, the timing does not
  assign fetch_byte = ext_sync ? bus_sync : code_data;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= CCS_S1;
      phase2 <= 1'b0;
    end else if (clk_en) begin
      phase2 <= !phase2;
      if (phase2) begin
        state <= next_state;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      second_cycle <= 1'b0;
      instr_done <= 1'b0;
    end else if (clk_en) begin
      instr_done <= end_of_cycle && last_cycle;
      if (end_of_cycle) begin
        second_cycle <= !last_cycle;
      end
    end
  end

  // Branch evaluation in S3 of the last cycle, result applied at S4 phase two
  logic br_eval;
  logic br_taken;
  logic [15:0] br_target;

  assign br_eval = last_cycle && (branch_kind != CCS_BR_NONE) && phase2 && (state == CCS_S3);

  ccs_branch_eval u_branch (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .eval(br_eval),
    .kind(branch_kind),
    .acc_value(acc_value),
    .byte_a(byte_a),
    .byte_b(byte_b),
    .rel(operand_last),
    .next_pc(pc),
    .taken(br_taken),
    .target(br_target),
    .carry_value(carry_value),
    .carry_write(carry_write),
    .dec_value(dec_value),
    .dec_write(dec_write)
  );

  // Fetch slots: opcode captured at S1 phase two, second byte at S4 phase two
  logic take_opcode;
  logic take_s1_operand;
  logic take_s4_operand;

  assign take_opcode = phase2 && (state == CCS_S1) && !second_cycle;
  assign take_s1_operand = phase2 && (state == CCS_S1) && second_cycle && fetch_ok && need_operand;
  // A fetch the instruction does not need is read and dropped
  assign take_s4_operand = phase2 && (state == CCS_S4) && fetch_ok && need_operand;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      instr_reg <= CCS_BYTE_RESET;
    end else if (clk_en && take_opcode) begin
      instr_reg <= fetch_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      operand_last <= CCS_BYTE_RESET;
      operand_prev <= CCS_BYTE_RESET;
    end else if (clk_en && (take_s1_operand || take_s4_operand)) begin
      operand_prev <= operand_last;
      operand_last <= fetch_byte;
    end
  end

  // Program counter advances only on consumed bytes; a taken branch wins at S4 phase two
  logic br_apply;
  logic br_taken_d;

  // br_taken stands only in S4 phase one, so carry it one period into phase two
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      br_taken_d <= 1'b0;
    end else if (clk_en) begin
      br_taken_d <= br_taken;
    end
  end

  assign br_apply = br_taken_d && phase2 && (state == CCS_S4);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc <= CCS_PC_RESET;
    end else if (clk_en) begin
      if (br_apply) begin
        pc <= br_target;
      end else if (take_opcode || take_s1_operand || take_s4_operand) begin
        pc <= pc + CCS_PC_STEP;
      end
    end
  end

  assign code_addr = pc;

  // External bus timing
  logic external_data_move_cycle1;
  logic ale_opcode;
  logic ale_second;
  logic ale_data;
  logic program_store_read_strobe_opcode;
  logic program_store_read_strobe_second;
  logic data_window;

  assign external_data_move_cycle1 = instr_is_external_data_move && !second_cycle;
  // Opcode address of the next cycle goes out at S5 phase two; replaced by the data address in a move
  assign ale_opcode = phase2 && (state == CCS_S5) && !(external_data_move_cycle1);
  assign ale_data = phase2 && (state == CCS_S5) && external_data_move_cycle1;
  // No second-fetch address in the move's second cycle: the one dropped latch pulse
  assign ale_second = phase2 && (state == CCS_S2) && fetch_ok;
  // Read windows: S6 to S1 for the opcode, S3 to S4 for the second byte
  // The move's own opcode window in S1 of its first cycle still runs; only S6 of cycle one and S1 of cycle two go
  assign program_store_read_strobe_opcode = (state == CCS_S6 && !external_data_move_cycle1) || (state == CCS_S1 && !external_data_move_cycle2);
  assign program_store_read_strobe_second = (state == CCS_S3 || state == CCS_S4) && fetch_ok;
  // Data window S6 of the first cycle through S3 of the second: four states against two
  assign data_window = (external_data_move_cycle1 && state == CCS_S6) ||
                       (external_data_move_cycle2 && (state == CCS_S1 || state == CCS_S2 || state == CCS_S3));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      address_latch_strobe <= 1'b0;
    end else if (clk_en) begin
      // Runs in both program modes so it can serve as a clock output
      address_latch_strobe <= ale_opcode || ale_second || ale_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      program_store_read_strobe_n <= 1'b1;
    end else if (clk_en) begin
      // Held inactive for on-chip code; two low pulses per cycle otherwise, one per cycle in an external data move
      program_store_read_strobe_n <= !(ext_sync && (program_store_read_strobe_opcode || program_store_read_strobe_second));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_strobe_n <= 1'b1;
      data_write_n <= 1'b1;
    end else if (clk_en) begin
      data_strobe_n <= !(data_window && !data_write);
      data_write_n <= !(data_window && data_write);
    end
  end

  // Port drivers: address during the latch strobe, write data in a data write
  logic drive_prog_addr;
  logic [15:0] prog_addr;

  assign drive_prog_addr = ext_sync && (ale_opcode || ale_second);
  assign prog_addr = pc;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      low_address_data_port_o <= CCS_BYTE_RESET;
      low_address_data_port_oe <= 1'b0;
    end else if (clk_en) begin
      if (ale_data) begin
        low_address_data_port_o <= data_addr[7:0];
        low_address_data_port_oe <= 1'b1;
      end else if (drive_prog_addr) begin
        low_address_data_port_o <= prog_addr[7:0];
        low_address_data_port_oe <= 1'b1;
      end else if (data_window && data_write) begin
        low_address_data_port_o <= data_wr_byte;
        low_address_data_port_oe <= 1'b1;
      end else begin
        // Released so the latch sees a stable byte only while the strobe is high
        low_address_data_port_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      high_address_port_o <= CCS_BYTE_RESET;
      high_address_port_oe <= 1'b0;
    end else if (clk_en) begin
      if (ale_data) begin
        high_address_port_o <= data_addr[15:8];
        high_address_port_oe <= 1'b1;
      end else if (drive_prog_addr) begin
        high_address_port_o <= prog_addr[15:8];
        high_address_port_oe <= 1'b1;
      end else if (!ext_sync && !data_window) begin
        high_address_port_oe <= 1'b0;
      end
    end
  end

  // Read data taken at the end of the data window, after the synchroniser delay
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_rd_byte <= CCS_BYTE_RESET;
      data_rd_valid <= 1'b0;
    end else if (clk_en) begin
      data_rd_valid <= external_data_move_cycle2 && !data_write && phase2 && (state == CCS_S4);
      if (external_data_move_cycle2 && !data_write && phase2 && (state == CCS_S4)) begin
        data_rd_byte <= bus_sync;
      end
    end
  end

endmodule : ccs_sequencer

`default_nettype wire

// ===== bench/ccs_seq_props.sv
// Concurrent checks on the sequencer pins and branch results
`default_nettype none
module ccs_seq_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Operands and mode
  input wire logic external_program,
  input wire logic [7:0] byte_a,
  input wire logic [7:0] byte_b,
  // Sequencer outputs
  input wire ccs_pkg::ccs_state_e state,
  input wire logic phase2,
  input wire logic carry_value,
  input wire logic carry_write,
  input wire logic [7:0] dec_value,
  input wire logic dec_write,
  input wire logic address_latch_strobe,
  input wire logic program_store_read_strobe_n,
  input wire logic low_address_data_port_oe,
  input wire logic high_address_port_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence read_window;
    !program_store_read_strobe_n [*4] ##1 program_store_read_strobe_n;
  endsequence
  sequence latch_gap;
    !address_latch_strobe [*5];
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) !resetn && clk_en |=> state == CCS_S1 && !phase2
    && !address_latch_strobe && program_store_read_strobe_n && !low_address_data_port_oe)
    else $error("reset state wrong");
  phase_toggle_a: assert property (clk_en |=> phase2 != $past(phase2))
    else $error("phase did not toggle");
  state_hold_a: assert property (clk_en && !phase2 |=> state == $past(state))
    else $error("state left after one period");
  state_step_a: assert property (clk_en && phase2 && state != CCS_S6 |=>
    state == ccs_state_e'($past(state) + 3'd1)) else $error("state did not step");
  state_wrap_a: assert property (clk_en && phase2 && state == CCS_S6 |=> state == CCS_S1)
    else $error("state did not wrap");
  latch_gap_a: assert property (address_latch_strobe |=> latch_gap)
    else $error("latch strobes too close");
  read_len_a: assert property ($fell(program_store_read_strobe_n) |-> read_window)
    else $error("read strobe length wrong");
  internal_quiet_a: assert property (!external_program && !$past(external_program, 10)
    |-> program_store_read_strobe_n) else $error("read strobe in internal mode");
  addr_drive_a: assert property (address_latch_strobe && external_program && $past(external_program, 10)
    |-> low_address_data_port_oe && high_address_port_oe) else $error("address not driven");
  dec_value_a: assert property (dec_write |-> dec_value == byte_a - 8'h01)
    else $error("decrement wrong");
  carry_cmp_a: assert property (carry_write |-> carry_value == (byte_a < byte_b))
    else $error("carry wrong");
endmodule : ccs_seq_props
bind ccs_sequencer ccs_seq_props u_props (.ref_clk, .resetn, .clk_en, .external_program, .byte_a, .byte_b,
  .state, .phase2, .carry_value, .carry_write, .dec_value, .dec_write, .address_latch_strobe,
  .program_store_read_strobe_n, .low_address_data_port_oe, .high_address_port_oe);
`default_nettype wire

// ===== bench/ccs_ext_mem.sv
// External program and data memory behind the low address latch
`default_nettype none
module ccs_ext_mem (
  // Clock
  input wire logic ref_clk,
  // Bus strobes
  input wire logic ale,
  input wire logic read_n,
  input wire logic data_n,
  // Address and data pins
  input wire logic [7:0] low_o,
  input wire logic low_oe,
  input wire logic [7:0] high_o,
  output logic [7:0] low_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held_low;
  logic [7:0] last = 8'h00;
  always_ff @(posedge ref_clk) begin
    if (ale) begin
      held_low <= low_o;
    end
    last <= low_level;
  end
  // A released bus shows the inverse of its last level so stale data never looks valid
  always_comb begin
    if (low_oe) begin
      low_level = low_o;
    end else if (!read_n || !data_n) begin
      low_level = held_low ^ high_o ^ 8'hA5;
    end else begin
      low_level = ~last;
    end
  end
endmodule : ccs_ext_mem
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the machine-cycle sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic external_program = 1'b0;
  logic instr_two_cycle = 1'b0;
  logic instr_is_external_data_move = 1'b0;
  logic need_operand = 1'b0;
  ccs_branch_e branch_kind = CCS_BR_NONE;
  logic [7:0] acc_value = 8'h00;
  logic [7:0] byte_a = 8'h00;
  logic [7:0] byte_b = 8'h00;
  logic data_write = 1'b0;
  logic [15:0] pc;
  ccs_state_e state;
  logic phase2, instr_done, carry_value, carry_write, dec_write, ale, read_n, data_n, low_oe;
  logic [7:0] dec_value, low_o, high_o, port_level;
  int num_errors = 0;
  int num_checks = 0;
  int cyc, ale_n, rd_n;
  logic [15:0] dpc;
  logic cw, cv, dw;
  logic [7:0] dv;
  logic rd_valid, rv;
  logic [7:0] rd_byte, rdb, ireg, oplast;
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Every on-chip code byte reads as +64, so a taken branch shows as a large pc jump
  ccs_sequencer u_dut (.ref_clk, .resetn, .clk_en(1'b1), .external_program, .code_addr(), .code_data(8'h40),
    .instr_two_cycle, .instr_is_external_data_move, .need_operand, .branch_kind, .acc_value, .byte_a, .byte_b,
    .data_addr(16'h3C5A), .data_write, .data_wr_byte(8'h96), .data_rd_byte(rd_byte), .data_rd_valid(rd_valid),
    .instr_reg(ireg), .operand_last(oplast), .operand_prev(), .pc, .state, .phase2, .second_cycle(), .instr_done,
    .carry_value,
    .carry_write, .dec_value, .dec_write, .address_latch_strobe(ale), .program_store_read_strobe_n(read_n),
    .data_strobe_n(data_n), .data_write_n(), .low_address_data_port_o(low_o), .low_address_data_port_oe(low_oe),
    .low_address_data_port_i(port_level), .high_address_port_o(high_o), .high_address_port_oe());
  ccs_ext_mem u_mem (.ref_clk, .ale, .read_n, .data_n, .low_o, .low_oe, .high_o, .low_level(port_level));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // Runs one instruction from phase one of its first state to its done pulse
  task automatic issue(input logic ext, input logic two, input logic mv, input ccs_branch_e k,
                       input logic [7:0] acc, input logic [7:0] a, input logic [7:0] b);
    logic prev;
    logic [15:0] p0;
    p0 = pc;
    prev = read_n;
    ale_n = 0;
    rd_n = 0;
    cw = 1'b0;
    dw = 1'b0;
    rv = 1'b0;
    rdb = 8'h00;
    @(posedge ref_clk);
    external_program <= ext;
    instr_two_cycle <= two;
    instr_is_external_data_move <= mv;
    need_operand <= (k != CCS_BR_NONE);
    branch_kind <= k;
    acc_value <= acc;
    byte_a <= a;
    byte_b <= b;
    for (cyc = 2; cyc < 40; cyc++) begin
      @(posedge ref_clk);
      // A three-byte branch ends at S1 of its second cycle, so the S4 fetch that follows is not needed
      if (cyc == 15) begin
        need_operand <= 1'b0;
      end
      #1;
      if (rd_valid === 1'b1) begin
        rv = 1'b1;
        rdb = rd_byte;
      end
      ale_n += int'(ale === 1'b1);
      rd_n += int'(prev === 1'b1 && read_n === 1'b0);
      prev = read_n;
      if (carry_write === 1'b1) begin
        cw = 1'b1;
        cv = carry_value;
      end
      if (dec_write === 1'b1) begin
        dw = 1'b1;
        dv = dec_value;
      end
      if (instr_done === 1'b1) begin
        break;
      end
    end
    dpc = pc - p0;
  endtask : issue
  task automatic run_plain(input logic ext, input logic mv);
    issue(ext, mv, mv, CCS_BR_NONE, 8'h00, 8'h00, 8'h00);
  endtask : run_plain
  task automatic t_reset();
    chk(state, CCS_S1);
    chk({phase2, ale, read_n, data_n, low_oe, pc}, {5'b00110, 16'h0000});
    $display("Test reset done");
  endtask : t_reset
  task automatic t_internal();
    run_plain(1'b0, 1'b0);
    chk(cyc, 12);
    chk(ale_n, 2);
    chk(rd_n, 0);
    chk(dpc, 1);
    chk(ireg, 8'h40);
    $display("Test internal done");
  endtask : t_internal
  task automatic t_external();
    run_plain(1'b1, 1'b0);
    run_plain(1'b1, 1'b0);
    chk(cyc, 12);
    chk(ale_n, 2);
    chk(rd_n, 2);
    chk(dpc, 1);
    $display("Test external done");
  endtask : t_external
  task automatic t_move();
    run_plain(1'b1, 1'b1);
    chk(cyc, 24);
    chk(ale_n, 3);
    chk(rd_n, 2);
    chk(dpc, 1);
    // Model answers a read with latched low ^ high port ^ A5: 5A ^ 3C ^ A5
    chk({rv, rdb}, {1'b1, 8'hC3});
    run_plain(1'b0, 1'b1);
    run_plain(1'b0, 1'b1);
    chk(cyc, 24);
    chk(ale_n, 3);
    chk(rd_n, 0);
    chk({rv, rdb}, {1'b1, 8'hC3});
    $display("Test move done");
  endtask : t_move
  task automatic br(input ccs_branch_e k, input logic [7:0] a, input logic [7:0] b, input logic tk,
                    input logic c);
    issue(1'b0, 1'b1, 1'b0, k, a, a, b);
    chk(cyc, 24);
    chk(dpc, tk ? 16'd67 : 16'd3);
    chk(oplast, 8'h40);
    if (k == CCS_BR_CMP_UNEQUAL) begin
      chk({cw, cv}, {1'b1, c});
    end
    if (k == CCS_BR_DEC_NONZERO) begin
      chk({dw, dv}, {1'b1, a - 8'h01});
    end
  endtask : br
  task automatic t_branch();
    br(CCS_BR_ACC_ZERO, 8'h00, 8'h05, 1'b1, 1'b0);
    br(CCS_BR_ACC_ZERO, 8'h80, 8'h00, 1'b0, 1'b0);
    br(CCS_BR_ACC_NONZERO, 8'h01, 8'h00, 1'b1, 1'b0);
    br(CCS_BR_ACC_NONZERO, 8'h00, 8'h05, 1'b0, 1'b0);
    br(CCS_BR_DEC_NONZERO, 8'h01, 8'h00, 1'b0, 1'b0);
    br(CCS_BR_DEC_NONZERO, 8'h00, 8'h00, 1'b1, 1'b0);
    br(CCS_BR_CMP_UNEQUAL, 8'h03, 8'h07, 1'b1, 1'b1);
    br(CCS_BR_CMP_UNEQUAL, 8'h09, 8'h07, 1'b1, 1'b0);
    br(CCS_BR_CMP_UNEQUAL, 8'h07, 8'h07, 1'b0, 1'b0);
    $display("Test branch done");
  endtask : t_branch
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    t_reset();
    @(posedge ref_clk);
    resetn <= 1'b1;
    for (cyc = 0; cyc < 40 && instr_done !== 1'b1; cyc++) begin
      @(posedge ref_clk);
      #1;
    end
    t_internal();
    t_external();
    t_move();
    t_branch();
    print_verdict();
  end
  // The whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    $display("Watchdog expired");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
